// file: verification/swat_det_model.sv
// energy detector and receiver front end model
`timescale 1ns/1ps
module swat_det_model
    import swat_pkg::*;
(
    input  wire logic       clk,
    input  wire swat_det_t  det,
    input  wire logic       noise_on,
    input  wire logic       id_sent,
    input  wire logic [3:0] id_lat,
    output logic            energy_det,
    output logic            id_ok
);
    logic [3:0] on_cnt_r;
    ////////////////////////////////////////////////////////////////////////////////
    // cycles since receiver came on
    always_ff @(posedge clk) begin
        if (!det.rx_on)
            on_cnt_r <= 4'h0;
        else if (on_cnt_r != 4'hF)
            on_cnt_r <= on_cnt_r + 4'h1;
    end
    // background energy above threshold
    assign energy_det = noise_on;
    // identifier only while receiving, after latency
    assign id_ok = id_sent && det.rx_on && (on_cnt_r >= id_lat);
endmodule : swat_det_model

// file: verification/swat_top_asserts.sv
// checker: port-level properties of the sniff scheduler
`timescale 1ns/1ps
module swat_top_asserts
    import swat_pkg::*;
#(
    parameter logic [7:0] THR_STEP = 8'h01
) (
    input wire logic       SYS_CLK,
    input wire logic       SRST,
    input wire logic [7:0] ADDR,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       ID_OK,
    input wire swat_det_t  DET,
    input wire logic       WAKE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    ////////////////////////////////////////////////////////////////////////////////
    a_bw_hz_match:
        assert property (DET.rx_on |-> DET.bw_hz == (BW_BASE_HZ << DET.bw_sel))
        else $error("filter bandwidth does not match code");
    a_opt_read_zero:
        assert property (RD && ADDR == ADR_SNIFF_OPT |=> RDATA[2:1] == 2'h0)
        else $error("unused option bits read nonzero");
    a_thr_step_one:
        assert property (!$past(SRST) && !$past(SRST, 2) && !$past(WR) && !$past(WR, 2) && $changed(DET.thresh)
            |-> DET.thresh == $past(DET.thresh) + THR_STEP || DET.thresh == $past(DET.thresh) - THR_STEP)
        else $error("threshold moved by other than one step");
    a_wake_after_id:
        assert property (WAKE |-> $past(ID_OK, 2) || $past(ID_OK, 3) || $past(ID_OK, 4))
        else $error("wake without identifier");
    a_wake_ends_rx:
        assert property (WAKE |-> $past(DET.rx_on) && !DET.rx_on ##1 !WAKE)
        else $error("wake not a single pulse ending receive");
    a_chan_range:
        assert property (DET.chan <= NUM_CHAN - 4'h1)
        else $error("channel index out of range");
    a_chan_step:
        assert property ($changed(DET.chan) && DET.chan != 4'h0 |-> DET.chan == $past(DET.chan) + 4'h1)
        else $error("channel scan skipped a channel");
    a_thr_readback:
        assert property (!$past(WR) && RD && ADDR == ADR_THRESH ##1 $stable(DET.thresh) |-> RDATA == DET.thresh)
        else $error("threshold register differs from detector level");
    c_wake: cover property (WAKE);
    c_chan_last: cover property (DET.chan == 4'h8);
    c_thr_move: cover property (!$past(WR) && $changed(DET.thresh));
endmodule : swat_top_asserts

bind swat_top swat_top_asserts #(.THR_STEP(THR_STEP)) u_swat_top_asserts (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ID_OK(ID_OK), .DET(DET), .WAKE(WAKE)
);

// file: verification/testbench.sv
// self-checking bench for the sniff scheduler
`timescale 1ns/1ps
module testbench;
    import swat_pkg::*;
    logic       SYS_CLK = 1'b0;
    logic       SRST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic       WR = 1'b0;
    logic       RD = 1'b0;
    logic       RX_START = 1'b0;
    logic [2:0] RX_FILTER_SEL = 3'h0;
    logic       noise_on = 1'b0;
    logic       id_sent = 1'b0;
    logic [7:0] RDATA;
    logic       ENERGY_DET;
    logic       ID_OK;
    swat_det_t  DET;
    logic       WAKE;
    int         errors = 0;
    int         total_checks = 0;
    int         win[4] = '{0, 100, 500, 100};
    int         codes[3] = '{1, 3, 2};
    logic [7:0] d;
    logic [7:0] v;
    logic [2:0] bw;
    logic [15:0] m;
    int         n, n1, n2, p, t, thr;

    swat_top #(.TICK_500US_CYC(5), .TICK_100MS_CYC(20)) u_swat_top (
        .SYS_CLK(SYS_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .RX_START(RX_START), .RX_FILTER_SEL(RX_FILTER_SEL),
        .ENERGY_DET(ENERGY_DET), .ID_OK(ID_OK), .DET(DET), .WAKE(WAKE)
    );
    swat_det_model u_swat_det_model (
        .clk(SYS_CLK), .det(DET), .noise_on(noise_on), .id_sent(id_sent), .id_lat(4'h2),
        .energy_det(ENERGY_DET), .id_ok(ID_OK)
    );

    initial begin
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge SYS_CLK);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge SYS_CLK);
        ADDR <= a; WDATA <= x; WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge SYS_CLK);
        ADDR <= a; RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1 x = RDATA;
    endtask : rd
    task automatic wait_rx(input logic lvl, output int k);
        k = 0;
        while (DET.rx_on !== lvl && k < 30000) begin
            step(1);
            k++;
        end
        chk(k < 30000, 1'b1);
    endtask : wait_rx
    task automatic count_thr(output int k);
        logic [7:0] t0;
        logic       pr;
        int         i;
        k = 0;
        t0 = DET.thresh;
        pr = DET.rx_on;
        for (i = 0; i < 30000 && DET.thresh === t0; i++) begin
            step(1);
            if (DET.rx_on === 1'b1 && pr !== 1'b1) k++;
            pr = DET.rx_on;
        end
        chk(i < 30000, 1'b1);
    endtask : count_thr
    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        errors++;
        stop_test();
    end
    initial begin
        void'($urandom(1064));
        repeat (10) @(posedge SYS_CLK);
        SRST <= 1'b0;
        step(2);
        rd(ADR_THRESH, d); chk(d, RST_THRESH);
        v = 8'($urandom);
        wr(ADR_TARGET, v); rd(ADR_TARGET, d); chk(d, v);
        wr(8'h3C, v); rd(8'h3C, d); chk(d, 8'h00);
        wr(ADR_SNIFF_OPT, 8'hFF); rd(ADR_SNIFF_OPT, d); chk(d, OPT_MASK);
        // interval timing per resolution, impulse listen
        bw = 3'($urandom);
        @(posedge SYS_CLK) RX_FILTER_SEL <= bw ^ 3'h5;
        wr(ADR_LISTEN, 8'h00); wr(ADR_CODE_DWELL, 8'h00);
        for (int r = 0; r < 2; r++) begin
            p = 2 + $urandom_range(4);
            wr(ADR_PERIOD, p[7:0]); wr(ADR_SNIFF_OPT, {bw, 4'h0, r[0]}); wr(ADR_IDLE_CFG, 8'h01);
            wait_rx(1'b1, n); wait_rx(1'b0, n); wait_rx(1'b1, n);
            chk(DET.bw_sel, bw);
            chk(DET.chan, 4'h0);
            wait_rx(1'b0, n1); chk(n1 <= 3, 1'b1);
            wait_rx(1'b1, n2);
            t = n1 + n2 - p * (r ? 20 : 5);
            chk(t >= -2 && t <= 3, 1'b1);
            wr(ADR_IDLE_CFG, 8'h00);
        end
        // dwell long enough for the sniff filter to settle
        wr(ADR_LISTEN, 8'h02); wr(ADR_PERIOD, 8'h01); wr(ADR_IDLE_CFG, 8'h01);
        wait_rx(1'b0, n); wait_rx(1'b1, n); wait_rx(1'b0, n1);
        chk(n1 >= 5000 && n1 <= 5003, 1'b1);
        wr(ADR_IDLE_CFG, 8'h00); wr(ADR_LISTEN, 8'h00);
        // multi-channel scan
        wr(ADR_SCAN, 8'h01); wr(ADR_IDLE_CFG, 8'h01);
        wait_rx(1'b0, n); wait_rx(1'b1, n);
        m = 16'h0000;
        for (int i = 0; i < 100 && DET.rx_on === 1'b1; i++) begin
            m = m | (16'h0001 << DET.chan);
            step(1);
        end
        chk(m, 16'h01FF);
        wr(ADR_IDLE_CFG, 8'h00); wr(ADR_SCAN, 8'h00);
        // auto threshold raising over each window
        wr(ADR_TARGET, 8'h00); wr(ADR_THRESH, 8'h40);
        thr = 8'h40;
        noise_on <= 1'b1;
        wr(ADR_IDLE_CFG, 8'h01);
        foreach (codes[i]) begin
            wr(ADR_SNIFF_OPT, {bw, codes[i][1:0], 3'h0});
            count_thr(n); count_thr(n);
            thr = thr + 2;
            chk(DET.thresh, thr[7:0]);
            chk(n, win[codes[i]]);
        end
        // identifiers found: fewer false wakes than target
        wr(ADR_CODE_DWELL, 8'h01); wr(ADR_TARGET, 8'h05);
        id_sent <= 1'b1;
        count_thr(n);
        thr = thr - 1;
        chk(DET.thresh, thr[7:0]);
        wr(ADR_SNIFF_OPT, {bw, 5'h00});
        step(6000);
        chk(DET.thresh, thr[7:0]);
        // receive command with wake-on-energy, listen until energy
        wr(ADR_IDLE_CFG, 8'h00);
        noise_on <= 1'b0;
        wr(ADR_LISTEN, 8'hFF); wr(ADR_RX_CFG, 8'h01);
        step(100);
        @(posedge SYS_CLK) RX_START <= 1'b1;
        @(posedge SYS_CLK) RX_START <= 1'b0;
        step(3000);
        chk(DET.rx_on, 1'b1);
        chk(DET.bw_sel, bw ^ 3'h5);
        chk(DET.thresh, thr[7:0]);
        noise_on <= 1'b1;
        n = 0;
        while (WAKE !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        chk(n < 100, 1'b1);
        // second reset in mid-run
        @(posedge SYS_CLK) SRST <= 1'b1;
        step(3);
        @(posedge SYS_CLK) SRST <= 1'b0;
        step(2);
        rd(ADR_THRESH, d); chk(d, RST_THRESH);
        stop_test();
    end
endmodule : testbench

// file: verilog/swat_pkg.sv
// package: sniff scheduler constants and types
package swat_pkg;
    // register offsets
    localparam logic [7:0] ADR_RX_CFG     = 8'h0E;
    localparam logic [7:0] ADR_IDLE_CFG   = 8'h10;
    localparam logic [7:0] ADR_SNIFF_OPT  = 8'h11;
    localparam logic [7:0] ADR_PERIOD     = 8'h12;
    localparam logic [7:0] ADR_LISTEN     = 8'h13;
    localparam logic [7:0] ADR_THRESH     = 8'h14;
    localparam logic [7:0] ADR_STATUS     = 8'h15;
    localparam logic [7:0] ADR_CODE_DWELL = 8'h16;
    localparam logic [7:0] ADR_SCAN       = 8'h17;
    localparam logic [7:0] ADR_TARGET     = 8'h2F;

    // field positions
    localparam int OPT_BW_LSB   = 5;
    localparam int OPT_WIN_LSB  = 3;
    localparam int OPT_RES_BIT  = 0;
    localparam int IDLE_SNF_BIT = 0;
    localparam int RXC_WOE_BIT  = 0;
    localparam int SCAN_MC_BIT  = 0;
    localparam logic [7:0] OPT_MASK = 8'hF9;

    // values after reset
    localparam logic [7:0] RST_OPT    = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'h00;
    localparam logic [7:0] RST_LISTEN = 8'h00;
    localparam logic [7:0] RST_THRESH = 8'h80;
    localparam logic [7:0] RST_CODE   = 8'h00;
    localparam logic [7:0] RST_TARGET = 8'h00;

    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_FINE_NS     = 100_000;
    localparam int T_RES_FAST_NS = 500_000;
    localparam int T_RES_SLOW_NS = 100_000_000;
    localparam int CYC_100US = (T_FINE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_500US = (T_RES_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_100MS = (T_RES_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counts and codes
    localparam logic [8:0]  WIN_SHORT      = 9'h064;
    localparam logic [8:0]  WIN_LONG       = 9'h1F4;
    localparam logic [7:0]  LISTEN_IMPULSE = 8'h00;
    localparam logic [7:0]  LISTEN_FOREVER = 8'hFF;
    localparam logic [3:0]  NUM_CHAN       = 4'h9;
    localparam logic [15:0] BW_BASE_HZ     = 16'h012C;

    typedef enum logic [1:0] {ST_SLEEP, ST_LISTEN, ST_CODE} swat_state_t;

    typedef struct packed {
        logic        rx_on;
        logic [2:0]  bw_sel;
        logic [15:0] bw_hz;
        logic [7:0]  thresh;
        logic [3:0]  chan;
    } swat_det_t;
endpackage : swat_pkg

// file: verilog/swat_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module swat_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;
endmodule : swat_sync

// file: verilog/swat_ticker.sv
// restartable prescaler giving a one-cycle tick
`timescale 1ns/1ps
module swat_ticker #(
    parameter int unsigned CYC = 2500
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic restart,
    output logic      tick
);
    localparam int W = $clog2(CYC + 1);

    logic [W-1:0] cnt_r;
    wire          last = (cnt_r == W'(CYC - 1));

    always_ff @(posedge clk) begin
        if (srst || restart || last) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign tick = last;
endmodule : swat_ticker

// file: verilog/swat_top.sv
// sniff wake scheduler with automatic energy threshold
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RQ1: sniff filter code 7:5 selects bandwidth 300 Hz doubling to 38.4 kHz.
// RQ2: sniff cycles use the sniff filter code, not the receive one.
// RQ3: window code gives 100, 500, 100 sniff cycles; 00 disables.
// RQ4: auto threshold runs whenever window code is nonzero.
// RQ5: period end with false count above target raises threshold.
// RQ6: period end with false count below target lowers threshold.
// RQ7: new threshold overwrites the software threshold register.
// RQ8: multi-channel bit makes each sniff scan nine channels.
// RQ9: bit 0 picks interval step: 1 is 100 ms, 0 is 500 us.
// RQ10: sniff period equals period count times selected step.
// RQ11: listen time zero decides energy from one impulse sample.
// RQ12: listen time 1 to FE keeps receiver on that many 100 us.
// RQ13: listen time FF keeps receiver on until energy is seen.
// RQ14: same dwell timing serves receive commands with wake-on-energy.
// RQ15: one threshold serves both wake-on-energy receive and sniff.
// RQ16: software sets dwell long enough for sniff filter settling.
// RQ17: software may need a fixed dwell such as 10 ms.
// RQ18: target register at 2F holds allowed false wakes per period.
// RQ19: energy seen but no identifier counts as a false wake.
// RQ20: no identifier within code dwell returns to sleep.
// RQ21: periodic sniff runs only with idle config bit 0 set.
// RQ22: cycle and false counters clear at each period end.
// RQ23: sniff option bits 2 and 1 do nothing and read zero.
module swat_top
    import swat_pkg::*;
#(
    parameter int unsigned TICK_500US_CYC = CYC_500US,
    parameter int unsigned TICK_100MS_CYC = CYC_100MS,
    parameter logic [7:0]  THR_STEP       = 8'h01
) (
    input  wire logic       SYS_CLK,
    input  wire logic       SRST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       RX_START,
    input  wire logic [2:0] RX_FILTER_SEL,
    input  wire logic       ENERGY_DET,
    input  wire logic       ID_OK,
    output swat_det_t       DET,
    output logic            WAKE
);
    ////////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic [8:0] win_len(input logic [1:0] code);
        case (code)
            2'b11:   win_len = WIN_SHORT;
            2'b10:   win_len = WIN_LONG;
            2'b01:   win_len = WIN_SHORT;
            default: win_len = 9'h000;
        endcase
    endfunction : win_len

    function automatic logic [15:0] bw_hz(input logic [2:0] code);
        bw_hz = BW_BASE_HZ << code;
    endfunction : bw_hz

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]  rxc_r;
    logic [7:0]  idle_r;
    logic [7:0]  opt_r;
    logic [7:0]  period_r;
    logic [7:0]  listen_r;
    logic [7:0]  thresh_r;
    logic [7:0]  code_r;
    logic [7:0]  scan_r;
    logic [7:0]  target_r;
    logic [7:0]  rdata_r;
    swat_state_t state_r;
    swat_state_t state_nxt;
    logic        sniff_r;
    logic        sniff_nxt;
    logic [3:0]  chan_r;
    logic [3:0]  chan_nxt;
    logic [7:0]  int_cnt_r;
    logic [7:0]  int_cnt_nxt;
    logic [7:0]  dw_cnt_r;
    logic [7:0]  dw_cnt_nxt;
    logic [8:0]  cyc_cnt_r;
    logic [8:0]  false_cnt_r;
    logic        restart;
    logic        cycle_end;
    logic        is_false;
    logic        wake_nxt;
    logic        wake_r;
    swat_det_t   det_r;
    logic [1:0]  pins_s;
    logic        tick_fine;
    logic        tick_fast;
    logic        tick_slow;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and timebases
    swat_sync #(
        .W (2)
    ) u_sync (
        .clk  (SYS_CLK),
        .srst (SRST),
        .d    ({ENERGY_DET, ID_OK}),
        .q    (pins_s)
    );

    wire energy_s = pins_s[1];
    wire id_ok_s  = pins_s[0];

    swat_ticker #(
        .CYC (CYC_100US)
    ) u_tick_fine (
        .clk     (SYS_CLK),
        .srst    (SRST),
        .restart (restart),
        .tick    (tick_fine)
    );

    swat_ticker #(
        .CYC (TICK_500US_CYC)
    ) u_tick_fast (
        .clk     (SYS_CLK),
        .srst    (SRST),
        .restart (1'b0),
        .tick    (tick_fast)
    );

    swat_ticker #(
        .CYC (TICK_100MS_CYC)
    ) u_tick_slow (
        .clk     (SYS_CLK),
        .srst    (SRST),
        .restart (1'b0),
        .tick    (tick_slow)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_rxc    = WR && (ADDR == ADR_RX_CFG);
    wire wr_idle   = WR && (ADDR == ADR_IDLE_CFG);
    wire wr_opt    = WR && (ADDR == ADR_SNIFF_OPT);
    wire wr_period = WR && (ADDR == ADR_PERIOD);
    wire wr_listen = WR && (ADDR == ADR_LISTEN);
    wire wr_thresh = WR && (ADDR == ADR_THRESH);
    wire wr_code   = WR && (ADDR == ADR_CODE_DWELL);
    wire wr_scan   = WR && (ADDR == ADR_SCAN);
    wire wr_target = WR && (ADDR == ADR_TARGET);

    wire [1:0] win_code = opt_r[OPT_WIN_LSB +: 2];
    wire [2:0] snf_bw   = opt_r[OPT_BW_LSB +: 3];
    wire       sniff_en = idle_r[IDLE_SNF_BIT];                  // [RQ21]
    wire       woe_en   = rxc_r[RXC_WOE_BIT];
    wire       multi    = scan_r[SCAN_MC_BIT];
    wire [8:0] win      = win_len(win_code);                     // [RQ3]
    wire       auto_en  = (win_code != 2'b00);                   // [RQ4]

    wire [7:0] status = {state_r == ST_CODE, state_r == ST_LISTEN, sniff_r, 1'b0, chan_r};

    wire [7:0] rd_mux =
        (ADDR == ADR_RX_CFG)     ? rxc_r    :
        (ADDR == ADR_IDLE_CFG)   ? idle_r   :
        (ADDR == ADR_SNIFF_OPT)  ? opt_r    :
        (ADDR == ADR_PERIOD)     ? period_r :
        (ADDR == ADR_LISTEN)     ? listen_r :
        (ADDR == ADR_THRESH)     ? thresh_r :
        (ADDR == ADR_STATUS)     ? status   :
        (ADDR == ADR_CODE_DWELL) ? code_r   :
        (ADDR == ADR_SCAN)       ? scan_r   :
        (ADDR == ADR_TARGET)     ? target_r : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rxc_r    <= 8'h00;
            idle_r   <= 8'h00;
            scan_r   <= 8'h00;
            code_r   <= RST_CODE;
        end else begin
            if (wr_rxc)  rxc_r  <= WDATA;
            if (wr_idle) idle_r <= WDATA;
            if (wr_scan) scan_r <= WDATA;
            if (wr_code) code_r <= WDATA;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            opt_r    <= RST_OPT;
            period_r <= RST_PERIOD;
            listen_r <= RST_LISTEN;
            target_r <= RST_TARGET;
        end else begin
            if (wr_opt)    opt_r    <= WDATA & OPT_MASK;       // [RQ23]
            if (wr_period) period_r <= WDATA;
            if (wr_listen) listen_r <= WDATA;
            if (wr_target) target_r <= WDATA;                   // [RQ18]
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= RD ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sniff interval timing
    wire tick_res = opt_r[OPT_RES_BIT] ? tick_slow : tick_fast;  // [RQ9]
    wire int_hit  = ({1'b0, int_cnt_r} + 9'h001) >= {1'b0, period_r};
    wire in_sleep = (state_r == ST_SLEEP);
    wire sniff_go = in_sleep && sniff_en && tick_res && int_hit;  // [RQ10]
    wire rx_go    = in_sleep && woe_en && RX_START;               // [RQ14]

    always_comb begin
        int_cnt_nxt = int_cnt_r;
        if (!in_sleep || !sniff_en) begin
            int_cnt_nxt = 8'h00;
        end else if (tick_res) begin
            int_cnt_nxt = int_hit ? 8'h00 : int_cnt_r + 8'h01;   // [RQ10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // dwell timing
    wire [7:0] dw_inc     = dw_cnt_r + 8'h01;
    wire       listen_end =
        (listen_r == LISTEN_IMPULSE) ? 1'b1 :                      // [RQ11]
        (listen_r == LISTEN_FOREVER) ? 1'b0 :                      // [RQ13]
        (tick_fine && (dw_inc == listen_r));                       // [RQ12]
    wire       code_end   = (code_r == 8'h00) || (tick_fine && (dw_inc == code_r));
    wire       last_chan  = !sniff_r || !multi || (chan_r == NUM_CHAN - 4'h1);

    ////////////////////////////////////////////////////////////////////////////
    // scheduler state machine
    always_comb begin
        state_nxt  = state_r;
        sniff_nxt  = sniff_r;
        chan_nxt   = chan_r;
        dw_cnt_nxt = tick_fine ? dw_inc : dw_cnt_r;
        restart    = 1'b0;
        cycle_end  = 1'b0;
        is_false   = 1'b0;
        wake_nxt   = 1'b0;
        case (state_r)
            ST_SLEEP: begin
                dw_cnt_nxt = 8'h00;
                if (rx_go) begin
                    state_nxt = ST_LISTEN;                          // [RQ14]
                    sniff_nxt = 1'b0;
                    chan_nxt  = 4'h0;
                    restart   = 1'b1;
                end else if (sniff_go) begin
                    state_nxt = ST_LISTEN;                          // [RQ21]
                    sniff_nxt = 1'b1;
                    chan_nxt  = 4'h0;
                    restart   = 1'b1;
                end
            end
            ST_LISTEN: begin
                if (energy_s) begin
                    state_nxt  = ST_CODE;                           // [RQ20]
                    dw_cnt_nxt = 8'h00;
                    restart    = 1'b1;
                end else if (listen_end && !last_chan) begin
                    chan_nxt   = chan_r + 4'h1;                     // [RQ8]
                    dw_cnt_nxt = 8'h00;
                    restart    = 1'b1;
                end else if (listen_end) begin
                    state_nxt = ST_SLEEP;
                    cycle_end = sniff_r;
                end
            end
            ST_CODE: begin
                if (id_ok_s) begin
                    state_nxt = ST_SLEEP;
                    wake_nxt  = 1'b1;
                    cycle_end = sniff_r;
                end else if (code_end) begin
                    state_nxt = ST_SLEEP;                           // [RQ20]
                    cycle_end = sniff_r;
                    is_false  = sniff_r;                            // [RQ19]
                end
            end
            default: begin
                state_nxt = ST_SLEEP;
                sniff_nxt = 1'b0;
                chan_nxt  = 4'h0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_r   <= ST_SLEEP;
            sniff_r   <= 1'b0;
            chan_r    <= 4'h0;
            int_cnt_r <= 8'h00;
            dw_cnt_r  <= 8'h00;
            wake_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            sniff_r   <= sniff_nxt;
            chan_r    <= chan_nxt;
            int_cnt_r <= int_cnt_nxt;
            dw_cnt_r  <= dw_cnt_nxt;
            wake_r    <= wake_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // automatic threshold
    wire [8:0] cyc_inc    = cyc_cnt_r + 9'h001;
    wire [8:0] false_tot  = false_cnt_r + {8'h00, is_false};
    wire       period_end = auto_en && cycle_end && (cyc_inc >= win);
    wire       over       = false_tot > {1'b0, target_r};          // [RQ5]
    wire       under      = false_tot < {1'b0, target_r};          // [RQ6]
    wire [7:0] thr_up     = (thresh_r > (8'hFF - THR_STEP)) ? 8'hFF : thresh_r + THR_STEP;
    wire [7:0] thr_dn     = (thresh_r < THR_STEP) ? 8'h00 : thresh_r - THR_STEP;
    wire [7:0] thr_adj    = over ? thr_up : (under ? thr_dn : thresh_r);

    always_ff @(posedge SYS_CLK) begin
        if (SRST || !auto_en || period_end) begin
            cyc_cnt_r   <= 9'h000;                                  // [RQ22]
            false_cnt_r <= 9'h000;                                  // [RQ22]
        end else if (cycle_end) begin
            cyc_cnt_r   <= cyc_inc;
            false_cnt_r <= false_tot;                               // [RQ19]
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            thresh_r <= RST_THRESH;
        end else if (period_end) begin
            thresh_r <= thr_adj;                                    // [RQ7]
        end else if (wr_thresh) begin
            thresh_r <= WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // detector control outputs
    wire [2:0] bw_nxt = sniff_nxt ? snf_bw : RX_FILTER_SEL;          // [RQ2]

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            det_r <= '0;
        end else begin
            det_r.rx_on  <= (state_nxt != ST_SLEEP);
            det_r.bw_sel <= bw_nxt;                                  // [RQ2]
            det_r.bw_hz  <= bw_hz(bw_nxt);                           // [RQ1]
            det_r.thresh <= thresh_r;                                // [RQ15]
            det_r.chan   <= chan_nxt;                                // [RQ8]
        end
    end

    assign DET   = det_r;
    assign WAKE  = wake_r;
    assign RDATA = rdata_r;
endmodule : swat_top
